/* File: design/rlt_pkg.sv */
// Constants, types and register map of the retriggerable staircase light timer.
package rlt_pkg;

  // ****************************************************************
  // Clock and timebase
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BASE_TICK_US  = 10_000;
  localparam int unsigned BASE_TICK_CYC = CLK_HZ / 1_000_000 * BASE_TICK_US;
  localparam int unsigned DIV_W         = 19;
  localparam logic [18:0] DIV_10MS      = 19'h00001;
  localparam logic [18:0] DIV_SEC       = 19'h00064;
  localparam logic [18:0] DIV_MIN       = 19'h01770;
  localparam logic [18:0] DIV_HOUR      = 19'h57e40;

  typedef enum logic [1:0] {
    RLT_TB_10MS = 2'b00,
    RLT_TB_SEC  = 2'b01,
    RLT_TB_MIN  = 2'b10,
    RLT_TB_HOUR = 2'b11
  } rlt_tb_t;

  // ****************************************************************
  // Times
  // ****************************************************************
  localparam int unsigned TIME_W = 16;

  typedef struct packed {
    logic [15:0] off_delay;
    logic [15:0] warn_lead;
    logic [15:0] warn_len;
  } rlt_times_t;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_OFF_DELAY = 5'h04;
  localparam logic [4:0] ADDR_WARN_LEAD = 5'h08;
  localparam logic [4:0] ADDR_WARN_LEN  = 5'h0c;
  localparam logic [4:0] ADDR_STATUS    = 5'h10;
  localparam logic [4:0] ADDR_ELAPSED   = 5'h14;

  localparam int unsigned CTRL_RETAIN_BIT   = 0;
  localparam int unsigned CTRL_WARN_EN_BIT  = 1;
  localparam int unsigned CTRL_TB_LSB       = 2;
  localparam int unsigned CTRL_SRC_T_BIT    = 4;
  localparam int unsigned CTRL_SRC_LEAD_BIT = 5;
  localparam int unsigned CTRL_SRC_LEN_BIT  = 6;
  localparam int unsigned CTRL_W            = 7;

  localparam logic [6:0]  CTRL_RESET      = 7'h00;
  localparam logic [15:0] OFF_DELAY_RESET = 16'h0064;
  localparam logic [15:0] WARN_LEAD_RESET = 16'h000a;
  localparam logic [15:0] WARN_LEN_RESET  = 16'h0002;

  localparam int unsigned STAT_LIGHT_BIT = 0;
  localparam int unsigned STAT_WARN_BIT  = 1;
  localparam int unsigned STAT_RUN_BIT   = 2;
  localparam int unsigned STAT_ON_BIT    = 3;

endpackage

/* File: design/rlt_tick_gen.sv */
// Timebase tick generator for the staircase light timer.
`timescale 1ns/1ps
module rlt_tick_gen #(
  parameter int unsigned BASE_CYC = rlt_pkg::BASE_TICK_CYC
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // Timebase selection and tick
  input  wire rlt_pkg::rlt_tb_t tb_sel,
  output logic                 tick
);
  import rlt_pkg::*;

  logic [31:0]      base_cnt_reg;
  logic             base_tick_reg;
  logic [DIV_W-1:0] sub_cnt_reg;
  logic             tick_reg;

  function automatic logic [DIV_W-1:0] div_of(input rlt_tb_t tb);
    unique case (tb)
      RLT_TB_10MS: div_of = DIV_10MS;
      RLT_TB_SEC:  div_of = DIV_SEC;
      RLT_TB_MIN:  div_of = DIV_MIN;
      RLT_TB_HOUR: div_of = DIV_HOUR;
    endcase
  endfunction

  // ****************************************************************
  // Base 10 ms prescaler
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt_reg  <= 32'h0;
      base_tick_reg <= 1'b0;
    end else if (base_cnt_reg >= BASE_CYC - 1) begin
      base_cnt_reg  <= 32'h0;
      base_tick_reg <= 1'b1;
    end else begin
      base_cnt_reg  <= base_cnt_reg + 32'h1;
      base_tick_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Selectable divider
  // ****************************************************************
  // A timebase change mid-count is caught by the >= compare instead of
  // letting the counter run past a shorter divisor.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_cnt_reg <= '0;
      tick_reg    <= 1'b0;
    end else if (base_tick_reg && sub_cnt_reg >= div_of(tb_sel) - 1'b1) begin
      sub_cnt_reg <= '0;
      tick_reg    <= 1'b1;
    end else begin
      if (base_tick_reg) begin
        sub_cnt_reg <= sub_cnt_reg + 1'b1;
      end
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;

endmodule

/* File: design/rlt_staircase_timer_block.sv */
// Retriggerable staircase light timer with pre-warning and retentivity.
//
// Notes on behaviour
// - A rising trigger edge switches the light output on at once.
// - The following falling trigger edge restarts the count from zero, light on.
// - The light goes off when the count equals the off-delay.
// - Optional pre-warning blanks the light at off-delay minus lead, for length.
// - Further trigger pulses while counting restart the count, extending on-time.
// - Retentive: output and count survive a power loss unchanged.
// - Non-retentive: output and count return to defaults when power returns.
// - A retentivity setting selects retentive or non-retentive operation.
// - Each time value comes from a constant or a live external value.
// - The counting timebase is selectable by configuration.
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
module rlt_staircase_timer_block #(
  parameter int unsigned BASE_TICK_CYC = rlt_pkg::BASE_TICK_CYC
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // Trigger, power and live time values
  input  wire logic               trg_in,
  input  wire logic               pwr_ok,
  input  wire rlt_pkg::rlt_times_t live_times,
  // Light outputs
  output logic                    light_out,
  output logic                    warn_active
);
  import rlt_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [CTRL_W-1:0] ctrl_reg;
  logic [15:0]       off_delay_reg;
  logic [15:0]       warn_lead_reg;
  logic [15:0]       warn_len_reg;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              trg_q_reg;
  logic              pwr_q_reg;
  logic              on_reg;
  logic              running_reg;
  logic [15:0]       elapsed_count;
  logic              light_reg;
  logic              warn_reg;
  logic              tick;
  logic              rise;
  logic              fall;
  logic              resume;
  logic              retain;
  logic              expire;
  logic              in_window;
  logic              bus_req;
  logic              wr_take;
  rlt_times_t        eff;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Window starts at off-delay minus lead, clamped at zero when the
  // lead exceeds the off-delay, and never reaches past the expiry.
  function automatic logic warn_win(input logic [15:0] e,
                                    input rlt_times_t t);
    logic [15:0] start;
    start = (t.warn_lead > t.off_delay) ? 16'h0000
                                        : t.off_delay - t.warn_lead;
    return (e >= start) && ((e - start) < t.warn_len)
           && (e < t.off_delay);
  endfunction

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // Every access waits one cycle, so read data come from a flop.
  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_reg;
  assign wr_take         = avs_write && ack_reg;
  assign avs_readdata    = rdata_reg;

  always_comb begin
    rdata_next = 32'h0;
    unique case (avs_address)
      ADDR_CTRL:      rdata_next = {25'h0, ctrl_reg};
      ADDR_OFF_DELAY: rdata_next = {16'h0, off_delay_reg};
      ADDR_WARN_LEAD: rdata_next = {16'h0, warn_lead_reg};
      ADDR_WARN_LEN:  rdata_next = {16'h0, warn_len_reg};
      ADDR_STATUS: begin
        rdata_next[STAT_LIGHT_BIT] = light_reg;
        rdata_next[STAT_WARN_BIT]  = warn_reg;
        rdata_next[STAT_RUN_BIT]   = running_reg;
        rdata_next[STAT_ON_BIT]    = on_reg;
      end
      ADDR_ELAPSED:   rdata_next = {16'h0, elapsed_count};
      default:        rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (avs_read && !ack_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg      <= CTRL_RESET;
      off_delay_reg <= OFF_DELAY_RESET;
      warn_lead_reg <= WARN_LEAD_RESET;
      warn_len_reg  <= WARN_LEN_RESET;
    end else if (wr_take) begin
      unique case (avs_address)
        ADDR_CTRL: begin
          ctrl_reg <= CTRL_W'(be_merge({25'h0, ctrl_reg}, avs_writedata,
                                       avs_byteenable));
        end
        ADDR_OFF_DELAY: begin
          off_delay_reg <= 16'(be_merge({16'h0, off_delay_reg},
                                        avs_writedata, avs_byteenable));
        end
        ADDR_WARN_LEAD: begin
          warn_lead_reg <= 16'(be_merge({16'h0, warn_lead_reg},
                                        avs_writedata, avs_byteenable));
        end
        ADDR_WARN_LEN: begin
          warn_len_reg <= 16'(be_merge({16'h0, warn_len_reg},
                                       avs_writedata, avs_byteenable));
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Time sources and timebase
  // ****************************************************************
  // Live values are taken every cycle, so a changing source moves the
  // expiry point while the count runs.
  always_comb begin
    eff.off_delay = ctrl_reg[CTRL_SRC_T_BIT] ? live_times.off_delay
                                             : off_delay_reg;
    eff.warn_lead = ctrl_reg[CTRL_SRC_LEAD_BIT] ? live_times.warn_lead
                                                : warn_lead_reg;
    eff.warn_len  = ctrl_reg[CTRL_SRC_LEN_BIT] ? live_times.warn_len
                                               : warn_len_reg;
  end

  rlt_tick_gen #(
    .BASE_CYC (BASE_TICK_CYC)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tb_sel  (rlt_tb_t'(ctrl_reg[CTRL_TB_LSB +: 2])),
    .tick    (tick)
  );

  // ****************************************************************
  // Timer core
  // ****************************************************************
  assign rise      = trg_in && !trg_q_reg;
  assign fall      = !trg_in && trg_q_reg;
  assign resume    = pwr_ok && !pwr_q_reg;
  assign retain    = ctrl_reg[CTRL_RETAIN_BIT];
  assign expire    = running_reg && (elapsed_count == eff.off_delay);
  assign in_window = ctrl_reg[CTRL_WARN_EN_BIT] && on_reg
                     && warn_win(elapsed_count, eff);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trg_q_reg <= 1'b0;
      pwr_q_reg <= 1'b0;
    end else begin
      trg_q_reg <= trg_in;
      pwr_q_reg <= pwr_ok;
    end
  end

  // While power is absent the state is frozen; on return it is either
  // kept or cleared, depending on retentivity.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_reg        <= 1'b0;
      running_reg   <= 1'b0;
      elapsed_count <= 16'h0;
    end else if (!pwr_ok) begin
      on_reg        <= on_reg;
      running_reg   <= running_reg;
      elapsed_count <= elapsed_count;
    end else if (resume && !retain) begin
      on_reg        <= 1'b0;
      running_reg   <= 1'b0;
      elapsed_count <= 16'h0;
    end else if (rise) begin
      on_reg        <= 1'b1;
      running_reg   <= 1'b0;
      elapsed_count <= 16'h0;
    end else if (fall && on_reg) begin
      running_reg   <= 1'b1;
      elapsed_count <= 16'h0;
    end else if (expire) begin
      on_reg      <= 1'b0;
      running_reg <= 1'b0;
    end else if (running_reg && tick) begin
      elapsed_count <= elapsed_count + 16'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      light_reg <= 1'b0;
      warn_reg  <= 1'b0;
    end else if (pwr_ok) begin
      light_reg <= on_reg && !in_window;
      warn_reg  <= in_window;
    end
  end

  assign light_out   = light_reg;
  assign warn_active = warn_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_rise_sets_on: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rise && pwr_ok && !(resume && !retain) |=> on_reg ##1 light_reg || warn_reg)
    else $error("rising trigger did not switch the light on");

  a_fall_restart: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    fall && on_reg && pwr_ok && !resume
    |=> running_reg && on_reg && elapsed_count == 16'h0)
    else $error("falling trigger did not restart the count");

  a_expire_off: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    expire && pwr_ok && !rise && !fall && !resume
    |=> !on_reg ##1 !light_reg)
    else $error("light stayed on after the off-delay");

  a_warn_blank: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    pwr_ok && on_reg && ctrl_reg[CTRL_WARN_EN_BIT]
    && warn_win(elapsed_count, eff) |=> !light_reg && warn_reg)
    else $error("light not blanked inside the warning window");

  a_retrig_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rise && pwr_ok && !resume
    |=> !running_reg && elapsed_count == 16'h0 && on_reg)
    else $error("retrigger did not restart the count");

  a_retain_freeze: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !pwr_ok ##1 pwr_ok && retain
    |-> on_reg == $past(on_reg) && elapsed_count == $past(elapsed_count))
    else $error("retentive state changed over the power loss");

  a_nonret_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    resume && !retain
    |=> !on_reg && !running_reg && elapsed_count == 16'h0)
    else $error("non-retentive state not cleared after power return");

  a_tick_step: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    pwr_ok && !resume && !rise && !fall && running_reg && tick && !expire
    |=> elapsed_count == $past(elapsed_count) + 16'h1)
    else $error("count did not advance by one on a tick");

  a_idle_count: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !tick && !rise && !fall && !resume
    |=> elapsed_count == $past(elapsed_count))
    else $error("count moved without a tick");

endmodule

/* File: dv/rlt_trg_src.sv */
// Trigger source model: a pushbutton pressed for a number of cycles.
`timescale 1ns/1ps
module rlt_trg_src (
  // Clock
  input  wire logic ref_clk,
  // Trigger line
  output logic      trg_in
);
  initial trg_in = 1'b0;
  // Called just after a rising edge; every change follows an edge.
  task automatic pulse(input int hi);
    trg_in <= 1'b1;
    repeat (hi) @(posedge ref_clk);
    trg_in <= 1'b0;
  endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the staircase light timer.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import rlt_pkg::*;
  localparam int P = 4;
  logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        trg_in, pwr_ok, light_out, warn_active, lit, dark;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, q1;
  logic [3:0]  avs_byteenable;
  rlt_times_t  live_times;
  int          bad_count, n_checks, jw1, jw2, jo, t, seed;
  int          reg_m [6];

  rlt_staircase_timer_block #(.BASE_TICK_CYC(P)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trg_in(trg_in), .pwr_ok(pwr_ok), .live_times(live_times),
    .light_out(light_out), .warn_active(warn_active));
  rlt_trg_src trg_src_u (.ref_clk(ref_clk), .trg_in(trg_in));

  always #5 ref_clk = ~ref_clk;

  task automatic wrap_up();
    $display("checks=%0d bad=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One bus cycle; held until waitrequest is seen low at a rising edge.
  task automatic bus_go(input logic [4:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    i = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      i++;
      if (i == 20) begin
        bad_count++;
        wrap_up();
      end
      @(posedge ref_clk);
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input int v);
    logic [31:0] r;
    bus_go(a, 1'b1, 32'(v), r);
    if (a <= ADDR_WARN_LEN) reg_m[a >> 2] = v & (a == 0 ? 'h7f : 'hffff);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    bus_go(a, 1'b0, 32'h0000_0000, r);
  endtask

  // Press, release, then count negedges until the light finally goes off.
  task automatic watch(input int hi);
    int j;
    jw1 = 0;
    jw2 = 0;
    jo = 0;
    dark = 1'b0;
    @(posedge ref_clk);
    trg_src_u.pulse(hi);
    for (j = 1; jo == 0; j++) begin
      @(negedge ref_clk);
      if (j == 1) lit = light_out;
      if (warn_active === 1'b1 && jw1 == 0) begin
        jw1 = j;
        dark = ~light_out;
      end
      if (warn_active === 1'b0 && jw1 != 0 && jw2 == 0) jw2 = j;
      if (light_out === 1'b0 && warn_active === 1'b0 &&
          (jw1 == 0 || jw2 != 0)) jo = j;
      if (j == 4000) begin
        bad_count++;
        wrap_up();
      end
    end
  endtask

  // Model: first tick after the fall comes 1 to p cycles later.
  function automatic logic in_win(int j, int tt, int p);
    return j >= p * (tt - 1) + 4 && j <= p * tt + 5;
  endfunction

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    pwr_ok = 1'b1;
    live_times = '0;
    seed = 32'h866e6d52;
    reg_m = '{0, 'h64, 'ha, 2, 0, 0};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(5'(i * 4), q);
      `CHK(q, 32'(reg_m[i]))
    end
    wr(ADDR_STATUS, 'hf);
    rd(ADDR_STATUS, q);
    `CHK(q, 32'h0000_0000)
    rd(5'h18, q);
    `CHK(q, 32'h0000_0000)
    for (int k = 0; k < 3; k++) begin
      t = 3 + $unsigned($random(seed)) % 8;
      wr(ADDR_OFF_DELAY, t);
      rd(ADDR_OFF_DELAY, q);
      `CHK(q, 32'(reg_m[1]))
      watch(3 + $unsigned($random(seed)) % 28);
      `CHK(lit, 1'b1)
      `CHK(in_win(jo, t, P), 1'b1)
    end
    wr(ADDR_OFF_DELAY, 10);
    @(posedge ref_clk);
    trg_src_u.pulse(3);
    repeat (20) @(posedge ref_clk);
    watch(4);
    `CHK(in_win(jo, 10, P), 1'b1)
    // Warning from registers, then the same times from live values.
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CTRL, m ? 'h72 : 'h02);
      wr(ADDR_OFF_DELAY, m ? 40 : 20);
      wr(ADDR_WARN_LEAD, m ? 9 : 6);
      wr(ADDR_WARN_LEN, m ? 5 : 3);
      @(posedge ref_clk);
      live_times <= '{off_delay: 16'h0014, warn_lead: 16'h0006,
                      warn_len: 16'h0003};
      watch(3);
      `CHK(dark, 1'b1)
      `CHK(jw2 - jw1, 12)
      `CHK(jo - jw1 >= 24 && jo - jw1 <= 26, 1'b1)
      `CHK(in_win(jo, 20, P), 1'b1)
    end
    wr(ADDR_CTRL, 'h04);
    wr(ADDR_OFF_DELAY, 2);
    watch(3);
    `CHK(in_win(jo, 2, P * 100), 1'b1)
    // Power loss in retentive mode, then in non-retentive mode.
    wr(ADDR_CTRL, 'h01);
    wr(ADDR_OFF_DELAY, 40);
    @(posedge ref_clk);
    trg_src_u.pulse(3);
    repeat (60) @(posedge ref_clk);
    pwr_ok <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(ADDR_ELAPSED, q1);
    repeat (50) @(posedge ref_clk);
    rd(ADDR_ELAPSED, q);
    `CHK(q, q1)
    `CHK(light_out, 1'b1)
    rd(ADDR_STATUS, q);
    `CHK(q, 32'h0000_000d)
    pwr_ok <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK(light_out, 1'b1)
    rd(ADDR_ELAPSED, q);
    `CHK(q >= q1 && q1 > 0, 1'b1)
    wr(ADDR_CTRL, 'h00);
    @(posedge ref_clk);
    trg_src_u.pulse(3);
    repeat (30) @(posedge ref_clk);
    pwr_ok <= 1'b0;
    repeat (10) @(posedge ref_clk);
    pwr_ok <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK(light_out, 1'b0)
    rd(ADDR_ELAPSED, q);
    `CHK(q, 32'h0000_0000)
    rd(ADDR_STATUS, q);
    `CHK(q, 32'h0000_0000)
    wrap_up();
  end
endmodule
